/* File: core/ssa_pkg.sv */
// Constants for the security settings command link: frame bytes,
// command codes, settings indices, field layouts and reset values.
// Assumes a single 100 MHz clock shared by both ends.
package ssa_pkg;
  localparam logic [7:0] SSA_START      = 8'h02;
  localparam logic [7:0] SSA_CMD_RD_REQ = 8'h10;
  localparam logic [7:0] SSA_CMD_WR_REQ = 8'h11;
  localparam logic [7:0] SSA_CMD_RD_CNF = 8'h50;
  localparam logic [7:0] SSA_CMD_WR_CNF = 8'h51;
  localparam logic [7:0] SSA_CMD_ERASE  = 8'h0D;
  localparam logic [7:0] SSA_ST_OK      = 8'h00;
  localparam logic [7:0] SSA_ST_FAIL    = 8'h01;
  localparam logic [7:0] SSA_IDX_SEC    = 8'h0C;
  localparam logic [7:0] SSA_IDX_PER    = 8'h2C;
  localparam logic [7:0] SSA_IDX_CODE   = 8'h12;
  localparam logic [7:0] SSA_SEC_RST    = 8'h00;
  localparam logic [7:0] SSA_PER_RST    = 8'h0B;
  localparam logic [7:0] SSA_RSVD_MASK  = 8'hF0;
  localparam logic [2:0] SSA_MODE_NONE  = 3'h0;
  localparam logic [2:0] SSA_MODE_JUST  = 3'h2;
  localparam logic [2:0] SSA_MODE_CODE  = 3'h3;
  localparam int         SSA_MODE_HI    = 2;
  localparam int         SSA_BOND_BIT   = 3;
  localparam int         SSA_CODE_LEN   = 6;
  localparam int         SSA_MAX_BONDS  = 32;
  localparam logic [7:0] SSA_DIGIT_LO   = 8'h30;
  localparam logic [7:0] SSA_DIGIT_HI   = 8'h39;
  localparam logic [47:0] SSA_CODE_RST  = 48'h333231333231;
  localparam int         SSA_FRM_MAX    = 12;
  localparam logic [3:0] SSA_IDX_W      = 4'h4;
  localparam logic [3:0] SSA_HDR_LEN    = 4'h4;
  localparam logic [7:0] SSA_ADR_CTRL   = 8'h00;
  localparam logic [7:0] SSA_ADR_INDEX  = 8'h01;
  localparam logic [7:0] SSA_ADR_VALUE  = 8'h02;
  localparam logic [7:0] SSA_ADR_STAT   = 8'h03;
  localparam logic [7:0] SSA_ADR_RDVAL  = 8'h04;
  localparam int         SSA_CTRL_RD    = 0;
  localparam int         SSA_CTRL_WR    = 1;
  localparam int         SSA_CTRL_ERASE = 2;
endpackage

/* File: core/ssa_link_if.sv */
// Byte link between host controller and security settings device.
// Each side sends one byte per cycle with a valid strobe; no back-pressure.
`timescale 1ns/1ns
`default_nettype none
interface ssa_link_if;
  logic [7:0] h2d_byte;
  logic       h2d_valid;
  logic [7:0] d2h_byte;
  logic       d2h_valid;
  modport dev  (input h2d_byte, input h2d_valid,
                output d2h_byte, output d2h_valid);
  modport host (output h2d_byte, output h2d_valid,
                input d2h_byte, input d2h_valid);
endinterface
`default_nettype wire

/* File: core/ssa_frame_rx.sv */
// Frame receiver shared by both ends: collects a frame into a byte
// buffer and checks the trailing check byte.
// Assumes bytes arrive from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ssa_frame_rx
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  in_byte,
  input  wire logic        in_valid,
  output logic             frame_ok,
  output logic             frame_bad,
  output logic [7:0]       frame_cmd,
  output logic [7:0]       frame_data [ssa_pkg::SSA_FRM_MAX],
  output logic [3:0]       frame_len
);
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] len_q, len_d;
  logic [7:0] cs_q, cs_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] buf_q [ssa_pkg::SSA_FRM_MAX];
  logic ok_q, ok_d, bad_q, bad_d;
  logic [3:0] dlen_q, dlen_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    len_d  = len_q;
    cs_d   = cs_q;
    cmd_d  = cmd_q;
    dlen_d = dlen_q;
    ok_d   = 1'b0;
    bad_d  = 1'b0;
    if (in_valid)
    begin
      cs_d = cs_q ^ in_byte;
      if (cnt_q == 4'h0)
      begin
        cs_d = in_byte;
        if (in_byte == ssa_pkg::SSA_START)
          cnt_d = 4'h1;
      end
      else if (cnt_q == 4'h1)
      begin
        cmd_d = in_byte;
        cnt_d = 4'h2;
      end
      else if (cnt_q == 4'h2)
      begin
        len_d[7:0] = in_byte;
        cnt_d = 4'h3;
      end
      else if (cnt_q == 4'h3)
      begin
        len_d[15:8] = in_byte;
        cnt_d = 4'h4;
        // A full buffer plus its check byte would wrap the 4-bit counter.
        if (in_byte != 8'h00 || len_q[7:0] >= 8'(ssa_pkg::SSA_FRM_MAX))
        begin
          bad_d = 1'b1;
          cnt_d = 4'h0;
        end
      end
      else if (16'(cnt_q - ssa_pkg::SSA_HDR_LEN) == len_q)
      begin
        cnt_d  = 4'h0;
        dlen_d = len_q[3:0];
        ok_d   = (cs_q == in_byte);
        bad_d  = (cs_q != in_byte);
      end
      else
        cnt_d = cnt_q + 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ssa_pkg::SSA_FRM_MAX; gi++)
    begin : g_buf
      always_ff @(posedge clk)
        if (rst)
          buf_q[gi] <= 8'h00;
        else if (in_valid && cnt_q == 4'(gi + 4))
          buf_q[gi] <= in_byte;
      assign frame_data[gi] = buf_q[gi];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q  <= 4'h0;
      len_q  <= 16'h0000;
      cs_q   <= 8'h00;
      cmd_q  <= 8'h00;
      dlen_q <= 4'h0;
      ok_q   <= 1'b0;
      bad_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      len_q  <= len_d;
      cs_q   <= cs_d;
      cmd_q  <= cmd_d;
      dlen_q <= dlen_d;
      ok_q   <= ok_d;
      bad_q  <= bad_d;
    end
  end

  assign frame_ok  = ok_q;
  assign frame_bad = bad_q;
  assign frame_cmd = cmd_q;
  assign frame_len = dlen_q;
endmodule
`default_nettype wire

/* File: core/ssa_device.sv */
// Device end: security settings store and confirm-frame generator.
// Assumes the host keeps reserved bits zero and pairing code digits valid.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Security config byte, index 12, reset zero.
// - Mode 0: no authentication, no encryption.
// - Mode 2: fresh keys, encrypted, no confirmation.
// - Mode 3: central must present pairing code.
// - Host writes only modes 0,2,3; reserved zero.
// - Bit 3 enables bonding.
// - At most 32 bonded peers kept.
// - Configured mode is minimum level enforced.
// - Host erases bonds after changing security.
// - Both paired modules use same mode.
// - Peripheral-only config, index 44, reset 11.
// - Read 0x10 answers 0x50, status, value.
// - Write 0x11 answers 0x51 with status.
// - Index 18 reads six-byte pairing code.
// - Frames start 0x02, fields LSB first.
// - Pairing code bytes are ASCII digits.
module ssa_device
(
  input  wire logic  MCLK,
  input  wire logic  RST,
  ssa_link_if.dev    LINK,
  input  wire logic  PERIPH_ONLY,
  input  wire logic  PEER_CONNECT,
  input  wire logic  PEER_CODE_OK,
  input  wire logic  PEER_BONDABLE,
  output logic       LINK_ENCRYPT,
  output logic       LINK_AUTH,
  output logic       LINK_ALLOW,
  output logic       BOND_ENABLE,
  output logic [5:0] BOND_COUNT
);
  typedef enum {S_IDLE, S_SEND} ssa_dstate_type;

  logic       ok, bad;
  logic [7:0] cmd;
  logic [7:0] dat [ssa_pkg::SSA_FRM_MAX];
  logic [3:0] dlen;

  ssa_frame_rx u_rx
  (
    .clk        (MCLK),
    .rst        (RST),
    .in_byte    (LINK.h2d_byte),
    .in_valid   (LINK.h2d_valid),
    .frame_ok   (ok),
    .frame_bad  (bad),
    .frame_cmd  (cmd),
    .frame_data (dat),
    .frame_len  (dlen)
  );

  // ---------------------------------------------------------------
  // Settings store and reply assembly
  // ---------------------------------------------------------------
  ssa_dstate_type st_q, st_d;
  logic [7:0]  sec_q, sec_d, per_q, per_d;
  logic [47:0] code_q, code_d;
  logic [7:0]  tx_q [ssa_pkg::SSA_FRM_MAX + 1];
  logic [7:0]  tx_d [ssa_pkg::SSA_FRM_MAX + 1];
  logic [3:0]  tlen_q, tlen_d, tpos_q, tpos_d;
  logic [7:0]  ob_q, ob_d;
  logic        ov_q, ov_d;
  logic [7:0]  cs;
  logic [7:0]  vlen;

  always_comb
  begin
    st_d   = st_q;
    sec_d  = sec_q;
    per_d  = per_q;
    code_d = code_q;
    tx_d   = tx_q;
    tlen_d = tlen_q;
    tpos_d = tpos_q;
    ob_d   = 8'h00;
    ov_d   = 1'b0;
    cs     = 8'h00;
    vlen   = 8'h00;
    case (st_q)
      S_IDLE:
        if (ok)
        begin
          tx_d[0] = ssa_pkg::SSA_START;
          tx_d[4] = ssa_pkg::SSA_ST_OK;
          tx_d[5] = 8'h00;
          tx_d[6] = 8'h00;
          tx_d[7] = 8'h00;
          tx_d[8] = 8'h00;
          tx_d[9] = 8'h00;
          tx_d[10] = 8'h00;
          tx_d[3] = 8'h00;
          if (cmd == ssa_pkg::SSA_CMD_RD_REQ && dlen == 4'h1)
          begin
            tx_d[1] = ssa_pkg::SSA_CMD_RD_CNF;
            vlen = 8'h01;
            if (dat[0] == ssa_pkg::SSA_IDX_SEC)
              tx_d[5] = sec_q;
            else if (dat[0] == ssa_pkg::SSA_IDX_PER)
              tx_d[5] = per_q;
            else if (dat[0] == ssa_pkg::SSA_IDX_CODE)
            begin
              vlen = 8'(ssa_pkg::SSA_CODE_LEN);
              for (int i = 0; i < ssa_pkg::SSA_CODE_LEN; i++)
                tx_d[5 + i] = code_q[8*i +: 8];
            end
            else
            begin
              vlen = 8'h00;
              tx_d[4] = ssa_pkg::SSA_ST_FAIL;
            end
          end
          else
          begin
            tx_d[1] = ssa_pkg::SSA_CMD_WR_CNF;
            if (cmd == ssa_pkg::SSA_CMD_WR_REQ && dlen == 4'h2
                && dat[0] == ssa_pkg::SSA_IDX_SEC)
              sec_d = dat[1];
            else if (cmd == ssa_pkg::SSA_CMD_WR_REQ && dlen == 4'h2
                     && dat[0] == ssa_pkg::SSA_IDX_PER)
              per_d = dat[1];
            else if (cmd == ssa_pkg::SSA_CMD_WR_REQ && dlen == 4'h7
                     && dat[0] == ssa_pkg::SSA_IDX_CODE)
              for (int i = 0; i < ssa_pkg::SSA_CODE_LEN; i++)
                code_d[8*i +: 8] = dat[1 + i];
            else if (cmd == ssa_pkg::SSA_CMD_ERASE)
              tx_d[1] = 8'(cmd + 8'h40);
            else
              tx_d[4] = ssa_pkg::SSA_ST_FAIL;
          end
          tx_d[2] = 8'(vlen + 8'h01);
          for (int i = 0; i < ssa_pkg::SSA_FRM_MAX - 1; i++)
            if (i < 5 + int'(vlen))
              cs = cs ^ tx_d[i];
          tx_d[5 + int'(vlen)] = cs;
          tlen_d = 4'(vlen + 8'h06);
          tpos_d = 4'h0;
          st_d   = S_SEND;
        end
      S_SEND:
      begin
        ob_d   = tx_q[tpos_q];
        ov_d   = 1'b1;
        tpos_d = tpos_q + 4'h1;
        if (tpos_q + 4'h1 == tlen_q)
          st_d = S_IDLE;
      end
      default:
        st_d = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Link policy and bond bookkeeping
  // ---------------------------------------------------------------
  logic [7:0] act;
  logic [2:0] mode;
  logic       enc_q, enc_d, auth_q, auth_d, allow_q, allow_d, bond_q, bond_d;
  logic [5:0] bcnt_q, bcnt_d;

  always_comb
  begin
    act     = PERIPH_ONLY ? per_q : sec_q;
    mode    = act[ssa_pkg::SSA_MODE_HI:0];
    bond_d  = act[ssa_pkg::SSA_BOND_BIT];
    enc_d   = (mode == ssa_pkg::SSA_MODE_JUST)
              || (mode == ssa_pkg::SSA_MODE_CODE);
    auth_d  = (mode == ssa_pkg::SSA_MODE_CODE);
    // The configured mode is a floor: peers failing it are refused.
    allow_d = (mode == ssa_pkg::SSA_MODE_NONE)
              || (mode == ssa_pkg::SSA_MODE_JUST)
              || (auth_d && PEER_CODE_OK);
    bcnt_d  = bcnt_q;
    if (ok && cmd == ssa_pkg::SSA_CMD_ERASE && st_q == S_IDLE)
      bcnt_d = 6'h00;
    else if (PEER_CONNECT && PEER_BONDABLE && bond_q && allow_q
             && bcnt_q < 6'(ssa_pkg::SSA_MAX_BONDS))
      bcnt_d = bcnt_q + 6'h01;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st_q    <= S_IDLE;
      sec_q   <= ssa_pkg::SSA_SEC_RST;
      per_q   <= ssa_pkg::SSA_PER_RST;
      code_q  <= ssa_pkg::SSA_CODE_RST;
      for (int i = 0; i <= ssa_pkg::SSA_FRM_MAX; i++)
        tx_q[i] <= 8'h00;
      tlen_q  <= 4'h0;
      tpos_q  <= 4'h0;
      ob_q    <= 8'h00;
      ov_q    <= 1'b0;
      enc_q   <= 1'b0;
      auth_q  <= 1'b0;
      allow_q <= 1'b0;
      bond_q  <= 1'b0;
      bcnt_q  <= 6'h00;
    end
    else
    begin
      st_q    <= st_d;
      sec_q   <= sec_d;
      per_q   <= per_d;
      code_q  <= code_d;
      tx_q    <= tx_d;
      tlen_q  <= tlen_d;
      tpos_q  <= tpos_d;
      ob_q    <= ob_d;
      ov_q    <= ov_d;
      enc_q   <= enc_d;
      auth_q  <= auth_d;
      allow_q <= allow_d;
      bond_q  <= bond_d;
      bcnt_q  <= bcnt_d;
    end
  end

  assign LINK.d2h_byte  = ob_q;
  assign LINK.d2h_valid = ov_q;
  assign LINK_ENCRYPT   = enc_q;
  assign LINK_AUTH      = auth_q;
  assign LINK_ALLOW     = allow_q;
  assign BOND_ENABLE    = bond_q;
  assign BOND_COUNT     = bcnt_q;
endmodule
`default_nettype wire

/* File: core/ssa_host.sv */
// Host end: turns register orders into request frames and reports the
// confirm frame. Assumes software keeps modes legal and codes numeric.
`timescale 1ns/1ns
`default_nettype none
module ssa_host
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  ssa_link_if.host         LINK,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [7:0]       RDATA
);
  typedef enum {H_IDLE, H_SEND, H_WAIT} ssa_hstate_type;

  logic       ok, bad;
  logic [7:0] cmd;
  logic [7:0] dat [ssa_pkg::SSA_FRM_MAX];
  logic [3:0] dlen;

  ssa_frame_rx u_rx
  (
    .clk        (MCLK),
    .rst        (RST),
    .in_byte    (LINK.d2h_byte),
    .in_valid   (LINK.d2h_valid),
    .frame_ok   (ok),
    .frame_bad  (bad),
    .frame_cmd  (cmd),
    .frame_data (dat),
    .frame_len  (dlen)
  );

  ssa_hstate_type st_q, st_d;
  logic [7:0] idx_q, idx_d, val_q, val_d, stat_q, stat_d, rv_q, rv_d;
  logic [7:0] rd_q, rd_d, ob_q, ob_d, cs_q, cs_d;
  logic       ov_q, ov_d, wr_q, wr_d, er_q, er_d;
  logic [2:0] pos_q, pos_d;
  logic [7:0] nb, op;

  always_comb
  begin
    st_d  = st_q;
    idx_d = idx_q;
    val_d = val_q;
    stat_d = stat_q;
    rv_d  = rv_q;
    wr_d  = wr_q;
    er_d  = er_q;
    pos_d = pos_q;
    cs_d  = cs_q;
    ob_d  = 8'h00;
    ov_d  = 1'b0;
    rd_d  = 8'h00;
    nb    = 8'h00;
    op    = er_q ? ssa_pkg::SSA_CMD_ERASE
            : (wr_q ? ssa_pkg::SSA_CMD_WR_REQ : ssa_pkg::SSA_CMD_RD_REQ);
    if (WR && ADDR == ssa_pkg::SSA_ADR_INDEX)
      idx_d = WDATA;
    if (WR && ADDR == ssa_pkg::SSA_ADR_VALUE)
      val_d = WDATA & ~ssa_pkg::SSA_RSVD_MASK;
    if (RD)
      case (ADDR)
        ssa_pkg::SSA_ADR_INDEX: rd_d = idx_q;
        ssa_pkg::SSA_ADR_VALUE: rd_d = val_q;
        ssa_pkg::SSA_ADR_STAT:  rd_d = stat_q;
        ssa_pkg::SSA_ADR_RDVAL: rd_d = rv_q;
        default:                rd_d = 8'h00;
      endcase
    case (st_q)
      H_IDLE:
        if (WR && ADDR == ssa_pkg::SSA_ADR_CTRL && WDATA[2:0] != 3'h0)
        begin
          wr_d   = WDATA[ssa_pkg::SSA_CTRL_WR];
          er_d   = WDATA[ssa_pkg::SSA_CTRL_ERASE];
          pos_d  = 3'h0;
          stat_d = 8'h80;
          st_d   = H_SEND;
        end
      H_SEND:
      begin
        case (pos_q)
          3'h0:    nb = ssa_pkg::SSA_START;
          3'h1:    nb = op;
          3'h2:    nb = er_q ? 8'h00 : (wr_q ? 8'h02 : 8'h01);
          3'h3:    nb = 8'h00;
          3'h4:    nb = er_q ? cs_q : idx_q;
          3'h5:    nb = wr_q ? val_q : cs_q;
          default: nb = cs_q;
        endcase
        ob_d  = nb;
        ov_d  = 1'b1;
        cs_d  = (pos_q == 3'h0) ? nb : (cs_q ^ nb);
        pos_d = pos_q + 3'h1;
        if ((er_q && pos_q == 3'h4) || (!er_q && !wr_q && pos_q == 3'h5)
            || pos_q == 3'h6)
          st_d = H_WAIT;
      end
      H_WAIT:
        if (ok)
        begin
          stat_d = dat[0];
          rv_d   = dat[1];
          st_d   = H_IDLE;
        end
        else if (bad)
        begin
          stat_d = 8'hFF;
          st_d   = H_IDLE;
        end
      default:
        st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st_q   <= H_IDLE;
      idx_q  <= 8'h00;
      val_q  <= 8'h00;
      stat_q <= 8'h00;
      rv_q   <= 8'h00;
      rd_q   <= 8'h00;
      ob_q   <= 8'h00;
      ov_q   <= 1'b0;
      cs_q   <= 8'h00;
      wr_q   <= 1'b0;
      er_q   <= 1'b0;
      pos_q  <= 3'h0;
    end
    else
    begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      val_q  <= val_d;
      stat_q <= stat_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
      ob_q   <= ob_d;
      ov_q   <= ov_d;
      cs_q   <= cs_d;
      wr_q   <= wr_d;
      er_q   <= er_d;
      pos_q  <= pos_d;
    end
  end

  assign LINK.h2d_byte  = ob_q;
  assign LINK.h2d_valid = ov_q;
  assign RDATA          = rd_q;
endmodule
`default_nettype wire

/* File: dv/ssa_link_assertions.sv */
// Checker for the byte link between the host and device ends.
// Assumes one clock and whole frames sent one byte per cycle.
`timescale 1ns/1ns
`default_nettype none
module ssa_link_assertions
(
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [7:0] h2d_byte,
  input wire logic       h2d_valid,
  input wire logic [7:0] d2h_byte,
  input wire logic       d2h_valid
);
  // ---------------------------------------------------------------
  // Frame trackers
  // ---------------------------------------------------------------
  logic [3:0] hp_q;
  logic [3:0] dp_q;
  logic [7:0] hl_q;
  logic [7:0] hx_q;
  logic [7:0] hc_q;
  logic [7:0] hi_q;
  logic [7:0] dl_q;
  logic [7:0] dx_q;
  logic       h_last;
  logic       h_ok;
  logic       d_last;
  assign h_last = h2d_valid && hp_q > 4'h3 && {4'h0, hp_q} == hl_q + 8'h04;
  assign h_ok   = h_last && h2d_byte == hx_q;
  assign d_last = d2h_valid && dp_q > 4'h3 && {4'h0, dp_q} == dl_q + 8'h04;
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      hp_q <= 4'h0;
      hx_q <= 8'h00;
      dp_q <= 4'h0;
      dx_q <= 8'h00;
    end
    else
    begin
      if (h2d_valid)
      begin
        hp_q <= h_last ? 4'h0 : hp_q + 4'h1;
        hx_q <= h_last ? 8'h00 : hx_q ^ h2d_byte;
        if (hp_q == 4'h1)
          hc_q <= h2d_byte;
        if (hp_q == 4'h2)
          hl_q <= h2d_byte;
        if (hp_q == 4'h4)
          hi_q <= h2d_byte;
      end
      if (d2h_valid)
      begin
        dp_q <= d_last ? 4'h0 : dp_q + 4'h1;
        dx_q <= d_last ? 8'h00 : dx_q ^ d2h_byte;
        if (dp_q == 4'h2)
          dl_q <= d2h_byte;
      end
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence s_req(c, i);
    h_ok && hc_q == c && hi_q == i;
  endsequence
  sequence s_rd_cnf(n);
    d2h_valid && d2h_byte == 8'h02 ##1 d2h_byte == 8'h50
      ##1 d2h_byte == n ##1 d2h_byte == 8'h00 ##1 d2h_byte == 8'h00;
  endsequence
  sequence s_wr_cnf;
    d2h_valid && d2h_byte == 8'h02 ##1 d2h_byte == 8'h51
      ##1 d2h_byte == 8'h01 ##1 d2h_byte == 8'h00;
  endsequence
  property p_start;
    d2h_valid && dp_q == 4'h0 |-> d2h_byte == 8'h02;
  endproperty
  property p_len_hi;
    d2h_valid && dp_q == 4'h3 |-> d2h_byte == 8'h00;
  endproperty
  property p_check;
    d_last |-> d2h_byte == dx_q;
  endproperty
  property p_run;
    d2h_valid && !d_last |=> d2h_valid;
  endproperty
  property p_cause;
    d2h_valid && dp_q == 4'h0 |-> $past(h_ok, 3);
  endproperty
  property p_rd_sec;
    s_req(8'h10, 8'h0C) |-> ##3 s_rd_cnf(8'h02);
  endproperty
  property p_rd_per;
    s_req(8'h10, 8'h2C) |-> ##3 s_rd_cnf(8'h02);
  endproperty
  property p_rd_code;
    s_req(8'h10, 8'h12) |-> ##3 s_rd_cnf(8'h07);
  endproperty
  property p_wr;
    h_ok && hc_q == 8'h11 |-> ##3 s_wr_cnf;
  endproperty
  property p_code_digit;
    d2h_valid && dl_q == 8'h07 && dp_q > 4'h4 && dp_q < 4'hB
      |-> d2h_byte >= 8'h30 && d2h_byte <= 8'h39;
  endproperty
  a_start: assert property (p_start)
    else $error("confirm frame does not open with the start byte");
  a_len_hi: assert property (p_len_hi)
    else $error("confirm length high byte not zero");
  a_check: assert property (p_check)
    else $error("confirm check byte wrong");
  a_run: assert property (p_run)
    else $error("confirm frame has a gap");
  a_cause: assert property (p_cause)
    else $error("confirm not three cycles after a good request");
  a_rd_sec: assert property (p_rd_sec)
    else $error("security config read confirm wrong");
  a_rd_per: assert property (p_rd_per)
    else $error("peripheral config read confirm wrong");
  a_rd_code: assert property (p_rd_code)
    else $error("pairing code read confirm wrong");
  a_wr: assert property (p_wr)
    else $error("write confirm wrong");
  a_code_digit: assert property (p_code_digit)
    else $error("pairing code byte is not a digit");
endmodule
`default_nettype wire

/* File: dv/security_settings_access_tb.sv */
// Testbench: host and device joined by one link, and a second device
// fed directly by the bench. Assumes a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module security_settings_access_tb;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       per = 1'b0;
  logic       pc = 1'b0;
  logic       pok = 1'b0;
  logic       pbd = 1'b0;
  logic [7:0] rdata;
  logic       enc;
  logic       auth;
  logic       allow;
  logic       bond;
  logic [5:0] bcnt;
  logic [7:0] rx_q [$];
  int         errors = 0;
  int         tests_run = 0;
  int         cycles = 0;
  ssa_link_if lk ();
  ssa_link_if lk2 ();
  always #5 mclk = ~mclk;
  ssa_host ssa_host_inst (.MCLK(mclk), .RST(rst), .LINK(lk.host),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  ssa_device ssa_device_inst (.MCLK(mclk), .RST(rst), .LINK(lk.dev),
    .PERIPH_ONLY(per), .PEER_CONNECT(pc), .PEER_CODE_OK(pok),
    .PEER_BONDABLE(pbd), .LINK_ENCRYPT(enc), .LINK_AUTH(auth),
    .LINK_ALLOW(allow), .BOND_ENABLE(bond), .BOND_COUNT(bcnt));
  ssa_device ssa_device_flt_inst (.MCLK(mclk), .RST(rst), .LINK(lk2.dev),
    .PERIPH_ONLY(per), .PEER_CONNECT(pc), .PEER_CODE_OK(pok),
    .PEER_BONDABLE(pbd), .LINK_ENCRYPT(), .LINK_AUTH(), .LINK_ALLOW(),
    .BOND_ENABLE(), .BOND_COUNT());
  ssa_link_assertions ssa_link_assertions_inst (.MCLK(mclk), .RST(rst),
    .h2d_byte(lk.h2d_byte), .h2d_valid(lk.h2d_valid),
    .d2h_byte(lk.d2h_byte), .d2h_valid(lk.d2h_valid));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (lk2.d2h_valid)
      rx_q.push_back(lk2.d2h_byte);
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic run_op(input int b, output logic [7:0] st);
    reg_wr(8'h00, 8'h01 << b);
    st = 8'h80;
    for (int n = 0; n < 60 && st === 8'h80; n++)
      reg_rd(8'h03, st);
  endtask
  task automatic set(input logic [7:0] i, v, es);
    logic [7:0] st;
    reg_wr(8'h01, i);
    reg_wr(8'h02, v);
    run_op(1, st);
    chk(st, es);
  endtask
  task automatic get(input logic [7:0] i, es, ev);
    logic [7:0] st;
    reg_wr(8'h01, i);
    run_op(0, st);
    chk(st, es);
    if (es == 8'h00)
    begin
      reg_rd(8'h04, st);
      chk(st, ev);
    end
  endtask
  task automatic peer(input logic ok, input logic bd);
    @(posedge mclk);
    pok <= ok;
    pbd <= bd;
    pc <= 1'b1;
    @(posedge mclk);
    pc <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic send2(input logic [7:0] cs);
    logic [7:0] b [6];
    b = '{8'h02, 8'h10, 8'h01, 8'h00, 8'h0C, cs};
    for (int k = 0; k < 6; k++)
    begin
      @(posedge mclk);
      lk2.h2d_byte <= b[k];
      lk2.h2d_valid <= 1'b1;
    end
    @(posedge mclk);
    lk2.h2d_valid <= 1'b0;
    lk2.h2d_byte <= ~cs;
    repeat (20) @(posedge mclk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    get(8'h0C, 8'h00, 8'h00);
    get(8'h2C, 8'h00, 8'h0B);
    get(8'h12, 8'h00, 8'h31);
    chk({6'h00, allow, enc | auth}, 8'h02);
  endtask
  task automatic t_modes();
    logic [7:0] v [3];
    v = '{8'h00, 8'h0A, 8'h03};
    for (int k = 0; k < 3; k++)
    begin
      set(8'h0C, v[k], 8'h00);
      get(8'h0C, 8'h00, v[k]);
      chk({7'h00, auth}, {7'h00, v[k] == 8'h03});
      chk({7'h00, bond}, {7'h00, v[k][3]});
      if (k < 2)
        chk({7'h00, enc}, {7'h00, v[k] == 8'h0A});
    end
    peer(1'b0, 1'b0);
    chk({7'h00, allow}, 8'h00);
    peer(1'b1, 1'b0);
    chk({7'h00, allow}, 8'h01);
  endtask
  task automatic t_periph();
    @(posedge mclk);
    per <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({6'h00, auth, bond}, 8'h03);
    set(8'h2C, 8'h02, 8'h00);
    get(8'h2C, 8'h00, 8'h02);
    chk({5'h00, enc, auth, bond}, 8'h04);
    @(posedge mclk);
    per <= 1'b0;
  endtask
  task automatic t_refuse();
    get(8'h0D, 8'h01, 8'h00);
    set(8'h0D, 8'h05, 8'h01);
  endtask
  task automatic t_bonds();
    logic [7:0] st;
    set(8'h0C, 8'h0A, 8'h00);
    run_op(2, st);
    chk(st, 8'h00);
    repeat (34) peer(1'b1, 1'b1);
    chk({2'h0, bcnt}, 8'h20);
    set(8'h0C, 8'h00, 8'h00);
    run_op(2, st);
    chk({2'h0, bcnt}, 8'h00);
  endtask
  task automatic t_fault();
    logic [7:0] x;
    rx_q.delete();
    send2(8'h00);
    chk(8'(rx_q.size()), 8'h00);
    send2(8'h1F);
    chk(8'(rx_q.size()), 8'h07);
    chk(rx_q[0], 8'h02);
    chk(rx_q[1], 8'h50);
    chk(rx_q[5], 8'h00);
    x = 8'h00;
    foreach (rx_q[k])
      x = x ^ rx_q[k];
    chk(x, 8'h00);
  endtask
  initial
  begin
    lk2.h2d_byte = 8'h00;
    lk2.h2d_valid = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_periph();
    t_refuse();
    t_bonds();
    t_fault();
    end_of_test();
  end
endmodule
`default_nettype wire
